// *** pkg/cmo_pkg.sv ***
package cmo_pkg;
   localparam int unsigned CMO_AW = 8;
   // register byte offsets
   localparam logic [7:0] OFS_CSS      = 8'h20;
   localparam logic [7:0] OFS_COC      = 8'h24;
   localparam logic [7:0] OFS_GATE2    = 8'h28;
   localparam logic [7:0] OFS_TRIM     = 8'h30;
   localparam logic [7:0] OFS_RST      = 8'h38;
   localparam logic [7:0] OFS_GATE3    = 8'h3C;
   localparam logic [7:0] OFS_IRQ_STS  = 8'h40;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
   // field positions
   localparam int unsigned CSS_MON      = 0;
   localparam int unsigned CSS_BACKUP   = 1;
   localparam int unsigned CSS_FAULT_IE = 2;
   localparam int unsigned CSS_FAULT    = 3;
   localparam int unsigned COC_EN       = 0;
   localparam int unsigned COC_SEL_LO   = 1;
   localparam int unsigned COC_READY_N  = 5;
   localparam int unsigned COC_BUSY     = 6;
   localparam int unsigned GATE2_WAKEUP = 2;
   localparam int unsigned GATE2_ADC    = 3;
   localparam int unsigned GATE3_TIMER  = 0;
   localparam int unsigned GATE3_SER2   = 1;
   localparam int unsigned GATE3_SER3   = 2;
   localparam int unsigned RST_WWDT     = 0;
   localparam int unsigned RST_IWDT     = 1;
   localparam int unsigned RST_SW       = 2;
   localparam int unsigned RST_EMC      = 4;
   localparam int unsigned IRQ_FAULT    = 0;
   localparam int unsigned IRQ_CO_READY = 1;
   // reset values, and the mask of clearable reset-cause flags
   localparam logic [7:0] GATE2_RST  = 8'hFF;
   localparam logic [2:0] GATE3_RST  = 3'h0;
   localparam logic [3:0] TRIM_RST   = 4'h0;
   localparam logic [3:0] COSEL_RST  = 4'h0;
   localparam logic [4:0] RST_MASK   = 5'h17;
   // master clock source codes
   localparam logic [7:0] MCLK_FAST  = 8'hE1;
   localparam logic [7:0] MCLK_SLOW  = 8'hD2;
   localparam logic [7:0] MCLK_XTAL  = 8'hB4;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned XTAL_MISS_NS  = 2000;
   localparam int unsigned CO_SETTLE_NS  = 400;
   localparam int unsigned XTAL_MISS_CYC = XTAL_MISS_NS / CLK_PERIOD_NS;
   localparam int unsigned CO_SETTLE_CYC = (CO_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W         = 16;

   typedef enum logic [2:0] {
      SRC_FAST_DIV = 3'b000,
      SRC_SLOW     = 3'b001,
      SRC_XTAL     = 3'b010,
      SRC_CPU      = 3'b011,
      SRC_FAST     = 3'b100,
      SRC_MASTER   = 3'b101,
      SRC_NONE     = 3'b110
   } cmo_src_t;

   typedef struct packed {
      logic emc;
      logic sw;
      logic iwdt;
      logic wwdt;
   } cmo_cause_t;

   typedef struct packed {
      logic serial3;
      logic serial2;
      logic adv_timer2;
      logic adc;
      logic wakeup;
   } cmo_gates_t;

   typedef struct packed {
      logic             x_s1;
      logic             x_s2;
      logic             x_s3;
      cmo_cause_t       c_s1;
      cmo_cause_t       c_s2;
      logic             mon_en;
      logic             backup_en;
      logic             fault_ie;
      logic             fault_flag;
      logic [CNT_W-1:0] miss_cnt;
      logic             co_en;
      logic [3:0]       co_sel;
      logic [CNT_W-1:0] co_cnt;
      logic             co_busy;
      cmo_src_t         co_src;
      logic [2:0]       co_div;
      logic [7:0]       gate2;
      logic [2:0]       gate3;
      logic [3:0]       trim;
      logic [4:0]       rst_flags;
      logic [1:0]       irq_sts;
      logic [1:0]       irq_mask;
      logic [7:0]       mclk_sel;
      logic             irq;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } cmo_state_t;
endpackage : cmo_pkg

// *** logic/cmo_clock_monitor.sv ***
`timescale 1ns/1ps
module cmo_clock_monitor
   import cmo_pkg::*;
#(
   parameter int unsigned MISS_CYC   = cmo_pkg::XTAL_MISS_CYC,
   parameter int unsigned SETTLE_CYC = cmo_pkg::CO_SETTLE_CYC
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [cmo_pkg::CMO_AW-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      xtal_clk_in,
   input  wire cmo_pkg::cmo_cause_t       cause_in,
   input  wire logic [7:0]                master_clk_cfg,
   output logic      [7:0]                master_clk_sel,
   output logic                           crystal_monitor_enable,
   output logic                           clk_out_enable,
   output cmo_pkg::cmo_src_t              clk_out_source,
   output logic      [2:0]                clk_out_div_log2,
   output cmo_pkg::cmo_gates_t            clk_gates,
   output logic      [3:0]                fast_osc_trim,
   output logic                           irq
);
   import cmo_pkg::*;

   if (MISS_CYC < 2 || MISS_CYC >= (1 << CNT_W)) begin : g_bad_miss
      $error("MISS_CYC out of range");
   end
   // busy must stand at least two cycles so software can see it
   if (SETTLE_CYC < 2 || SETTLE_CYC >= (1 << CNT_W)) begin : g_bad_settle
      $error("SETTLE_CYC out of range");
   end

   localparam logic [CNT_W-1:0] MISS_LAST = CNT_W'(MISS_CYC - 1);
   localparam logic [CNT_W-1:0] SETTLE    = CNT_W'(SETTLE_CYC);

   cmo_state_t s_q;
   cmo_state_t s_d;

   // select code to source and divide, as log2 of the divisor
   function automatic logic [5:0] decode_src(input logic [3:0] code);
      logic [5:0] r;
      r = {SRC_CPU, 3'h0};
      case (code)
         4'h0: r = {SRC_FAST_DIV, 3'h0};
         4'h1: r = {SRC_SLOW, 3'h0};
         4'h2: r = {SRC_XTAL, 3'h0};
         4'h3: r = {SRC_NONE, 3'h0};
         4'h5: r = {SRC_CPU, 3'h1};
         4'h6: r = {SRC_CPU, 3'h2};
         4'h7: r = {SRC_CPU, 3'h3};
         4'h8: r = {SRC_CPU, 3'h4};
         4'h9: r = {SRC_CPU, 3'h5};
         4'hA: r = {SRC_CPU, 3'h6};
         4'hB: r = {SRC_FAST, 3'h0};
         4'hC: r = {SRC_MASTER, 3'h0};
         default: r = {SRC_CPU, 3'h0};
      endcase
      return r;
   endfunction : decode_src

   logic        setup;
   logic        wr;
   logic        rd;
   logic        xtal_edge;
   logic        fault_evt;
   logic        ready_evt;
   logic [31:0] rword;
   logic        hit;
   logic [3:0]  new_sel;

   always_comb begin
      s_d       = s_q;
      setup     = psel & ~penable;
      // one zero-wait access per setup; write effect at the access edge
      wr        = psel & penable & s_q.pready & pwrite & pstrb[0];
      rd        = psel & penable & s_q.pready & ~pwrite;
      xtal_edge = s_q.x_s2 ^ s_q.x_s3;
      fault_evt = 1'b0;
      ready_evt = 1'b0;
      rword     = 32'h0000_0000;
      hit       = 1'b0;
      new_sel   = pwdata[COC_SEL_LO +: 4];

      s_d.x_s1 = xtal_clk_in;
      s_d.x_s2 = s_q.x_s1;
      s_d.x_s3 = s_q.x_s2;
      s_d.c_s1 = cause_in;
      s_d.c_s2 = s_q.c_s1;

      // crystal watchdog: a gap of MISS_CYC cycles without edges is a fault
      if (!s_q.mon_en || xtal_edge) begin
         s_d.miss_cnt = '0;
      end else if (s_q.miss_cnt == MISS_LAST) begin
         s_d.miss_cnt = '0;
         fault_evt    = 1'b1;
      end else begin
         s_d.miss_cnt = s_q.miss_cnt + CNT_W'(1);
      end

      if (s_q.co_busy) begin
         if (s_q.co_cnt <= CNT_W'(1)) begin
            s_d.co_busy = 1'b0;
            s_d.co_cnt  = '0;
            ready_evt   = 1'b1;
         end else begin
            s_d.co_cnt = s_q.co_cnt - CNT_W'(1);
         end
      end

      if (wr) begin
         if (paddr == OFS_CSS) begin
            s_d.mon_en     = pwdata[CSS_MON];
            s_d.backup_en  = pwdata[CSS_BACKUP];
            s_d.fault_ie   = pwdata[CSS_FAULT_IE];
            s_d.fault_flag = pwdata[CSS_FAULT] & s_q.fault_flag;
         end else if (paddr == OFS_COC) begin
            s_d.co_en  = pwdata[COC_EN];
            s_d.co_sel = new_sel;
            // a new source or a fresh enable restarts the settling window
            if (pwdata[COC_EN] && (!s_q.co_en || new_sel != s_q.co_sel)) begin
               s_d.co_busy = 1'b1;
               s_d.co_cnt  = SETTLE;
            end else if (!pwdata[COC_EN]) begin
               // a disabled output has nothing left to settle
               s_d.co_busy = 1'b0;
               s_d.co_cnt  = '0;
            end
         end else if (paddr == OFS_GATE2) begin
            s_d.gate2[GATE2_WAKEUP] = pwdata[GATE2_WAKEUP];
            s_d.gate2[GATE2_ADC]    = pwdata[GATE2_ADC];
         end else if (paddr == OFS_TRIM) begin
            s_d.trim = pwdata[3:0];
         end else if (paddr == OFS_RST) begin
            s_d.rst_flags = s_q.rst_flags & ~(pwdata[4:0] & RST_MASK);
         end else if (paddr == OFS_GATE3) begin
            s_d.gate3 = pwdata[2:0];
         end else if (paddr == OFS_IRQ_MASK) begin
            s_d.irq_mask = pwdata[1:0];
         end
      end

      // only the bits that software actually saw are cleared by the read
      if (rd && paddr == OFS_IRQ_STS) begin
         s_d.irq_sts = s_q.irq_sts & ~s_q.prdata[1:0];
      end

      // hardware sets come last so a same-cycle clear never hides an event
      if (fault_evt) begin
         s_d.fault_flag = 1'b1;
      end
      s_d.irq_sts[IRQ_FAULT]    = s_d.irq_sts[IRQ_FAULT] | fault_evt;
      s_d.irq_sts[IRQ_CO_READY] = s_d.irq_sts[IRQ_CO_READY] | ready_evt;
      s_d.rst_flags[RST_WWDT] = s_d.rst_flags[RST_WWDT] | s_q.c_s2.wwdt;
      s_d.rst_flags[RST_IWDT] = s_d.rst_flags[RST_IWDT] | s_q.c_s2.iwdt;
      s_d.rst_flags[RST_SW]   = s_d.rst_flags[RST_SW] | s_q.c_s2.sw;
      s_d.rst_flags[RST_EMC]  = s_d.rst_flags[RST_EMC] | s_q.c_s2.emc;

      // backup clock takes over from a failed crystal
      if (s_d.fault_flag && s_d.backup_en) begin
         s_d.mclk_sel = MCLK_FAST;
      end else begin
         s_d.mclk_sel = master_clk_cfg;
      end

      {s_d.co_src, s_d.co_div} = decode_src(s_d.co_sel);

      s_d.irq = (s_d.fault_flag & s_d.fault_ie) | (|(s_d.irq_sts & s_d.irq_mask));

      // answer is prepared in the setup cycle so pready is a flop, no wait
      s_d.pready  = setup;
      s_d.pslverr = 1'b0;
      if (setup) begin
         hit = 1'b1;
         if (paddr == OFS_CSS) begin
            rword[CSS_MON]      = s_q.mon_en;
            rword[CSS_BACKUP]   = s_q.backup_en;
            rword[CSS_FAULT_IE] = s_q.fault_ie;
            rword[CSS_FAULT]    = s_q.fault_flag;
         end else if (paddr == OFS_COC) begin
            rword[COC_EN]            = s_q.co_en;
            rword[COC_SEL_LO +: 4]   = s_q.co_sel;
            rword[COC_READY_N]       = ~s_q.co_en | s_q.co_busy;
            rword[COC_BUSY]          = s_q.co_busy;
         end else if (paddr == OFS_GATE2) begin
            rword[7:0] = s_q.gate2;
         end else if (paddr == OFS_TRIM) begin
            rword[3:0] = s_q.trim;
         end else if (paddr == OFS_RST) begin
            rword[4:0] = s_q.rst_flags;
         end else if (paddr == OFS_GATE3) begin
            rword[2:0] = s_q.gate3;
         end else if (paddr == OFS_IRQ_STS) begin
            rword[1:0] = s_q.irq_sts;
         end else if (paddr == OFS_IRQ_MASK) begin
            rword[1:0] = s_q.irq_mask;
         end else begin
            hit = 1'b0;
         end
         s_d.pslverr = ~hit;
         s_d.prdata  = pwrite ? 32'h0000_0000 : rword;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q          <= '0;
         s_q.co_sel   <= COSEL_RST;
         s_q.gate2    <= GATE2_RST;
         s_q.gate3    <= GATE3_RST;
         s_q.trim     <= TRIM_RST;
         s_q.mclk_sel <= MCLK_FAST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata                 = s_q.prdata;
   assign pready                 = s_q.pready;
   assign pslverr                = s_q.pslverr;
   assign master_clk_sel         = s_q.mclk_sel;
   assign crystal_monitor_enable = s_q.mon_en;
   assign clk_out_enable         = s_q.co_en;
   assign clk_out_source         = s_q.co_src;
   assign clk_out_div_log2       = s_q.co_div;
   assign clk_gates.wakeup       = s_q.gate2[GATE2_WAKEUP];
   assign clk_gates.adc          = s_q.gate2[GATE2_ADC];
   assign clk_gates.adv_timer2   = s_q.gate3[GATE3_TIMER];
   assign clk_gates.serial2      = s_q.gate3[GATE3_SER2];
   assign clk_gates.serial3      = s_q.gate3[GATE3_SER3];
   assign fast_osc_trim          = s_q.trim;
   assign irq                    = s_q.irq;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_irq_fault: assert property (s_q.fault_flag && s_q.fault_ie |-> irq)
      else $error("fault with enable but no interrupt");
   chk_irq_gated: assert property (!s_q.fault_ie && !(|(s_q.irq_sts & s_q.irq_mask)) |-> !irq)
      else $error("interrupt raised while gated");
   chk_fault_cause: assert property ($rose(s_q.fault_flag) |-> $past(s_q.mon_en, 1))
      else $error("fault flag set with monitor off");
   chk_zero_wait: assert property (psel && !penable |=> pready && !$past(penable))
      else $error("access not answered without wait");
   chk_backup_take: assert property (s_q.fault_flag && s_q.backup_en |-> master_clk_sel == MCLK_FAST)
      else $error("backup clock not selected after fault");
   chk_gate2_write: assert property (wr && paddr == OFS_GATE2 |=>
      clk_gates.adc == $past(pwdata[GATE2_ADC]) && clk_gates.wakeup == $past(pwdata[GATE2_WAKEUP]))
      else $error("gate two write lost");
   chk_gate3_write: assert property (wr && paddr == OFS_GATE3 |=>
      {clk_gates.serial3, clk_gates.serial2, clk_gates.adv_timer2} == $past(pwdata[2:0]))
      else $error("gate three write lost");
   chk_trim_write: assert property (wr && paddr == OFS_TRIM |=> fast_osc_trim == $past(pwdata[3:0]))
      else $error("trim write lost");
   chk_rst_keep: assert property (s_q.rst_flags[RST_SW] && !(wr && paddr == OFS_RST && pwdata[RST_SW])
      |=> s_q.rst_flags[RST_SW])
      else $error("reset cause flag cleared without write one");
   chk_busy_settle: assert property ($rose(s_q.co_busy) |-> s_q.co_busy [*2])
      else $error("busy window too short");
   chk_ready_sense: assert property (s_q.co_busy |-> s_q.co_en)
      else $error("busy while output disabled");
   chk_div_range: assert property (clk_out_div_log2 <= 3'h6)
      else $error("clock out divide out of range");
endmodule : cmo_clock_monitor

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
   import cmo_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, xtal_run;
   logic              xtal_clk_in = 1'b0;
   logic [7:0]        paddr, master_clk_cfg, master_clk_sel;
   logic [31:0]       pwdata, prdata, rdat;
   logic [3:0]        pstrb, fast_osc_trim;
   logic              pready, pslverr, crystal_monitor_enable, clk_out_enable, irq, rerr;
   logic [2:0]        clk_out_div_log2;
   cmo_cause_t        cause_in;
   cmo_src_t          clk_out_source;
   cmo_gates_t        clk_gates;
   int                err_count = 0;
   int                checks = 0;

   // short counts keep the fault and settle waits brief
   cmo_clock_monitor #(.MISS_CYC(4), .SETTLE_CYC(4)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .xtal_clk_in(xtal_clk_in), .cause_in(cause_in),
      .master_clk_cfg(master_clk_cfg), .master_clk_sel(master_clk_sel),
      .crystal_monitor_enable(crystal_monitor_enable), .clk_out_enable(clk_out_enable),
      .clk_out_source(clk_out_source), .clk_out_div_log2(clk_out_div_log2),
      .clk_gates(clk_gates), .fast_osc_trim(fast_osc_trim), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // crystal edges every third cycle stay well under half the bus clock
   always begin
      repeat (3) @(posedge pclk);
      if (xtal_run) xtal_clk_in <= ~xtal_clk_in;
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic cycle(input int n);
      repeat (n) @(posedge pclk);
   endtask : cycle

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(pready), 32'h1, "no ready");
      chk(32'(n), 32'h1, "wait states");
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp, msg);
   endtask : rd

   function automatic cmo_src_t exp_src(input int c);
      case (c)
         0: return SRC_FAST_DIV;
         1: return SRC_SLOW;
         2: return SRC_XTAL;
         3: return SRC_NONE;
         11: return SRC_FAST;
         12: return SRC_MASTER;
         default: return SRC_CPU;
      endcase
   endfunction : exp_src

   task automatic t_reset;
      rd(OFS_CSS, 32'h0000_0000, "css reset");
      rd(OFS_COC, 32'h0000_0020, "coc reset");
      rd(OFS_GATE2, 32'h0000_00FF, "gate2 reset");
      rd(OFS_TRIM, 32'h0000_0000, "trim reset");
      rd(OFS_GATE3, 32'h0000_0000, "gate3 reset");
      chk(32'(clk_gates), 32'h0000_0003, "gates reset");
      rd(8'h50, 32'h0000_0000, "unmapped data");
      chk(32'(rerr), 32'h1, "unmapped err");
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      wr(OFS_GATE2, 32'h0000_0000);
      rd(OFS_GATE2, 32'h0000_00F3, "gate2 clear");
      wr(OFS_GATE3, 32'h0000_0007);
      rd(OFS_GATE3, 32'h0000_0007, "gate3 set");
      chk(32'(clk_gates), 32'h0000_001C, "gates out");
      wr(OFS_GATE2, 32'h0000_0008);
      wr(OFS_GATE3, 32'h0000_0002);
      cycle(1);
      chk(32'(clk_gates), 32'h0000_000A, "gates mixed");
      wr(OFS_TRIM, 32'h0000_00FA);
      rd(OFS_TRIM, 32'h0000_000A, "trim");
      chk(32'(fast_osc_trim), 32'h0000_000A, "trim out");
      // a write without byte lane zero must leave the field alone
      pstrb <= 4'hE;
      wr(OFS_TRIM, 32'h0000_0005);
      pstrb <= 4'hF;
      rd(OFS_TRIM, 32'h0000_000A, "trim lane");
      $display("test regs done");
   endtask : t_regs

   task automatic t_cause;
      cause_in <= 4'hF;
      cycle(5);
      cause_in <= 4'h0;
      cycle(5);
      rd(OFS_RST, 32'h0000_0017, "causes set");
      wr(OFS_RST, 32'h0000_0000);
      rd(OFS_RST, 32'h0000_0017, "zero write");
      wr(OFS_RST, 32'h0000_0005);
      rd(OFS_RST, 32'h0000_0012, "partial clear");
      wr(OFS_RST, 32'h0000_0012);
      rd(OFS_RST, 32'h0000_0000, "all clear");
      $display("test cause done");
   endtask : t_cause

   task automatic t_fault;
      master_clk_cfg <= MCLK_SLOW;
      xtal_run <= 1'b1;
      wr(OFS_CSS, 32'h0000_0007);
      cycle(20);
      rd(OFS_CSS, 32'h0000_0007, "healthy");
      chk(32'(crystal_monitor_enable), 32'h1, "mon out");
      chk(32'(irq), 32'h0, "no irq");
      chk(32'(master_clk_sel), 32'(MCLK_SLOW), "cfg pass");
      xtal_run <= 1'b0;
      cycle(20);
      rd(OFS_CSS, 32'h0000_000F, "fault set");
      chk(32'(irq), 32'h1, "fault irq");
      chk(32'(master_clk_sel), 32'(MCLK_FAST), "backup sel");
      // stop the monitor first so no new fault can race the clear
      wr(OFS_CSS, 32'h0000_000E);
      rd(OFS_CSS, 32'h0000_000E, "flag kept");
      wr(OFS_CSS, 32'h0000_0006);
      cycle(2);
      chk(32'(irq), 32'h0, "irq removed");
      rd(OFS_CSS, 32'h0000_0006, "flag cleared");
      wr(OFS_CSS, 32'h0000_0001);
      cycle(20);
      rd(OFS_CSS, 32'h0000_0009, "gated fault");
      chk(32'(irq), 32'h0, "gated irq");
      wr(OFS_CSS, 32'h0000_0000);
      rd(OFS_IRQ_STS, 32'h0000_0001, "sts fault");
      rd(OFS_IRQ_STS, 32'h0000_0000, "sts read clear");
      $display("test fault done");
   endtask : t_fault

   task automatic t_clkout;
      for (int c = 0; c < 16; c++) begin
         wr(OFS_COC, 32'((c << 1) | 1));
         rd(OFS_COC, 32'((c << 1) | 32'h61), "busy");
         cycle(8);
         chk(32'(clk_out_source), 32'(exp_src(c)), "source");
         chk(32'(clk_out_div_log2), (c >= 5 && c <= 10) ? 32'(c - 4) : 32'h0, "div");
         rd(OFS_COC, 32'((c << 1) | 1), "ready");
      end
      chk(32'(clk_out_enable), 32'h1, "out en");
      wr(OFS_IRQ_MASK, 32'h0000_0002);
      cycle(2);
      chk(32'(irq), 32'h1, "ready irq");
      rd(OFS_IRQ_STS, 32'h0000_0002, "sts ready");
      cycle(2);
      chk(32'(irq), 32'h0, "irq after read");
      wr(OFS_COC, 32'h0000_0000);
      cycle(8);
      rd(OFS_COC, 32'h0000_0020, "disabled");
      $display("test clkout done");
   endtask : t_clkout

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      print_verdict();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      xtal_run = 1'b0;
      cause_in = 4'h0;
      master_clk_cfg = MCLK_FAST;
      cycle(3);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_cause();
      t_fault();
      t_clkout();
      print_verdict();
   end
endmodule : tb
